// *** design/flow_trace_pkg.sv ***
// flow trace port package: constants, command codes, pin bundle
// assumes nothing beyond a SystemVerilog compiler
package flow_trace_pkg;
   localparam int          ADDR_W      = 32;
   localparam int          DEPTH       = 8;
   localparam int          PTR_W       = 3;
   localparam int          CMD_BITS    = 8;
   localparam int          DATA_BITS   = 32;
   localparam int          CNT_W       = 7;
   localparam logic [31:0] TRACE_RESET = 32'h0000_0000;
   localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
   // command codes
   localparam logic [7:0]  CMD_READ_TRACE    = 8'h01;
   localparam logic [7:0]  CMD_READ_SCRATCH  = 8'h02;
   localparam logic [7:0]  CMD_WRITE_SCRATCH = 8'h03;
   localparam logic [7:0]  CMD_NOP           = 8'h04;
   localparam logic [7:0]  CMD_FACT_SELFTEST = 8'h1D;
   localparam logic [7:0]  CMD_FACT_CONTROL  = 8'h1E;
   localparam logic [7:0]  CMD_FACT_SCAN     = 8'h1F;

   typedef struct packed {
      logic selN;
      logic tck;
      logic tdi;
   } link_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD  = 2'b01,
      ST_DATA = 2'b10,
      ST_DONE = 2'b11
   } link_state_t;
endpackage

// *** design/pin_sync.sv ***
// two-flop synchroniser for a bundle of pins
// assumes inputs asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int           W   = 3,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // pins in, synchronised out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // reset to the pins' idle levels so no false edge follows reset
         meta_q <= RST;
         q      <= RST;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // pin_sync
`default_nettype wire

// *** design/debug_flow_trace_fifo.sv ***
// change-of-flow trace ring with serial debug command port
// assumes cof and debug signals on clk; serial pins asynchronous
`timescale 1ns/1ns
`default_nettype none
module debug_flow_trace_fifo (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // core side
   input  wire logic        cofValid,
   input  wire logic [31:0] cofAddr,
   input  wire logic        debugMode,
   output logic             debugAck,
   output logic [2:0]       tracePtr,
   // serial link
   input  wire logic        linkSelN,
   input  wire logic        linkTck,
   input  wire logic        linkTdi,
   output logic             linkTdo,
   output logic             linkTdoEn,
   output logic             execAck
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic isReadCmd(input logic [7:0] c);
      return (c == flow_trace_pkg::CMD_READ_TRACE) ||
             (c == flow_trace_pkg::CMD_READ_SCRATCH);
   endfunction

   function automatic logic isDataCmd(input logic [7:0] c);
      return isReadCmd(c) || (c == flow_trace_pkg::CMD_WRITE_SCRATCH);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   flow_trace_pkg::link_pins_t pinRaw;
   flow_trace_pkg::link_pins_t pinS;
   assign pinRaw = '{selN: linkSelN, tck: linkTck, tdi: linkTdi};

   // idle levels: select high, clock low, data low
   pin_sync #(.W(3), .RST(3'b100)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    (pinRaw),
      .q    (pinS)
   );

   logic                        tckPrev_q;
   flow_trace_pkg::link_state_t state_q;
   logic [6:0]                  bitCnt_q;
   logic [7:0]                  cmd_q;
   logic [31:0]                 shift_q;
   logic [31:0]                 scratch_q;
   logic [31:0]                 ring_q [flow_trace_pkg::DEPTH];
   logic [2:0]                  ptr_q;

   wire        tckRise  = pinS.tck & ~tckPrev_q;
   wire        tckFall  = ~pinS.tck & tckPrev_q;
   wire        active   = ~pinS.selN;
   wire        cmdLast  = (state_q == flow_trace_pkg::ST_CMD) && tckRise &&
                          (bitCnt_q == 7'(flow_trace_pkg::CMD_BITS - 1));
   wire [7:0]  cmdNext  = {pinS.tdi, cmd_q[7:1]};
   wire        dataLast = (state_q == flow_trace_pkg::ST_DATA) && tckRise &&
                          (bitCnt_q == 7'(flow_trace_pkg::DATA_BITS - 1));
   wire        readStb  = cmdLast && (cmdNext == flow_trace_pkg::CMD_READ_TRACE);
   wire        capture  = cofValid && !debugMode;
   wire [31:0] readWord = ring_q[ptr_q];
   wire [31:0] loadWord = (cmdNext == flow_trace_pkg::CMD_READ_TRACE) ? readWord
                                                                     : scratch_q;
   wire [2:0]  ptrInc   = 3'({2'b00, capture} + {2'b00, readStb});

   ////////////////////////////////////////////////////////////////////////////
   // trace ring
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= '0;
      end else begin
         ptr_q <= ptr_q + ptrInc;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < flow_trace_pkg::DEPTH; i++) begin
            ring_q[i] <= flow_trace_pkg::TRACE_RESET;
         end
      end else if (capture) begin
         ring_q[ptr_q] <= cofAddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial frame sequencer
   flow_trace_pkg::link_state_t stateNext;
   always_comb begin
      stateNext = state_q;
      case (state_q)
         flow_trace_pkg::ST_IDLE: if (active) stateNext = flow_trace_pkg::ST_CMD;
         flow_trace_pkg::ST_CMD:  if (cmdLast) begin
            stateNext = isDataCmd(cmdNext) ? flow_trace_pkg::ST_DATA
                                           : flow_trace_pkg::ST_DONE;
         end
         flow_trace_pkg::ST_DATA: if (dataLast) stateNext = flow_trace_pkg::ST_DONE;
         flow_trace_pkg::ST_DONE: stateNext = flow_trace_pkg::ST_DONE;
         default:                 stateNext = flow_trace_pkg::ST_IDLE;
      endcase
      if (!active) begin
         stateNext = flow_trace_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tckPrev_q <= 1'b0;
         state_q   <= flow_trace_pkg::ST_IDLE;
      end else begin
         tckPrev_q <= pinS.tck;
         state_q   <= stateNext;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bitCnt_q <= '0;
         cmd_q    <= '0;
      end else if (state_q == flow_trace_pkg::ST_IDLE || cmdLast) begin
         bitCnt_q <= '0;
         cmd_q    <= cmdLast ? cmdNext : '0;
      end else if (tckRise) begin
         bitCnt_q <= bitCnt_q + 7'h01;
         if (state_q == flow_trace_pkg::ST_CMD) begin
            cmd_q <= cmdNext;
         end
      end
   end

   // one register shifts in on rise and presents bit 0 on fall
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shift_q <= '0;
      end else if (cmdLast) begin
         shift_q <= isReadCmd(cmdNext) ? loadWord : '0;
      end else if (tckRise && state_q == flow_trace_pkg::ST_DATA) begin
         shift_q <= {pinS.tdi, shift_q[31:1]};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scratch_q <= flow_trace_pkg::SCRATCH_RESET;
      end else if (dataLast && cmd_q == flow_trace_pkg::CMD_WRITE_SCRATCH) begin
         scratch_q <= {pinS.tdi, shift_q[31:1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   wire ackSet = (cmdLast && cmdNext == flow_trace_pkg::CMD_NOP) ||
                 (dataLast && cmd_q == flow_trace_pkg::CMD_WRITE_SCRATCH);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         linkTdo   <= 1'b0;
         linkTdoEn <= 1'b0;
         execAck   <= 1'b0;
         debugAck  <= 1'b0;
         tracePtr  <= '0;
      end else begin
         if (tckFall && state_q == flow_trace_pkg::ST_DATA) begin
            linkTdo <= shift_q[0];
         end
         linkTdoEn <= (stateNext == flow_trace_pkg::ST_DATA) &&
                      (cmdLast ? isReadCmd(cmdNext) : isReadCmd(cmd_q));
         if (ackSet) begin
            execAck <= 1'b1;
         end else if (state_q == flow_trace_pkg::ST_IDLE && active) begin
            execAck <= 1'b0;
         end
         debugAck <= debugMode;
         tracePtr <= ptr_q + ptrInc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [2:0] lastWr_q;
   logic [3:0] fill_q;
   logic [2:0] entryPtr_q;
   logic [3:0] reads_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lastWr_q   <= '0;
         fill_q     <= '0;
         entryPtr_q <= '0;
         reads_q    <= '0;
      end else begin
         if (capture) begin
            lastWr_q <= ptr_q;
            if (fill_q != 4'h8) fill_q <= fill_q + 4'h1;
         end
         if (debugMode && !$past(debugMode)) begin
            entryPtr_q <= ptr_q;
            reads_q    <= {3'b000, readStb};
         end else if (readStb) begin
            reads_q    <= (reads_q == 4'h8) ? 4'h1 : reads_q + 4'h1;
         end
      end
   end

   sequence s_readLoad;
      readStb ##1 (state_q == flow_trace_pkg::ST_DATA);
   endsequence

   a_cof_advance: assert property (@(posedge clk) disable iff (!nrst)
      capture && !readStb |=> ptr_q == $past(ptr_q) + 3'h1 &&
      ring_q[$past(ptr_q)] == $past(cofAddr))
      else $error("capture did not store and advance");
   a_debug_frozen: assert property (@(posedge clk) disable iff (!nrst)
      debugMode && !readStb |=> ptr_q == $past(ptr_q))
      else $error("pointer moved in debug without read");
   a_read_advance: assert property (@(posedge clk) disable iff (!nrst)
      readStb && !capture |=> ptr_q == $past(ptr_q) + 3'h1)
      else $error("read did not advance pointer");
   a_read_word: assert property (@(posedge clk) disable iff (!nrst)
      s_readLoad |-> shift_q == $past(readWord))
      else $error("read word not entry under pointer");
   a_read_keeps: assert property (@(posedge clk) disable iff (!nrst)
      readStb && !capture |=> ring_q[$past(ptr_q)] == $past(readWord))
      else $error("read altered stored address");
   a_oldest_entry: assert property (@(posedge clk) disable iff (!nrst)
      $rose(debugMode) && fill_q == 4'h8 |-> ptr_q == lastWr_q + 3'h1)
      else $error("pointer not at oldest on debug entry");
   a_eight_reads: assert property (@(posedge clk) disable iff (!nrst)
      debugMode && reads_q == 4'h8 && $rose(reads_q == 4'h8) |-> ptr_q == entryPtr_q)
      else $error("eight reads did not restore pointer");
   a_cmd_lsb: assert property (@(posedge clk) disable iff (!nrst)
      cmdLast |=> cmd_q[7] == $past(pinS.tdi) && cmd_q[6:0] == $past(cmd_q[7:1]))
      else $error("command not shifted lsb first");
   a_nop_ack: assert property (@(posedge clk) disable iff (!nrst)
      cmdLast && cmdNext == flow_trace_pkg::CMD_NOP |=>
      execAck && state_q == flow_trace_pkg::ST_DONE)
      else $error("no-data command not acknowledged");
   a_debug_ack: assert property (@(posedge clk) disable iff (!nrst)
      $rose(debugMode) |=> debugAck ##1 1'b1)
      else $error("debug entry not acknowledged");
endmodule // debug_flow_trace_fifo
`default_nettype wire

// *** bench/link_host_model.sv ***
// serial debug controller model driving the link pins
// assumes the caller waits for debugAck before the first frame
`timescale 1ns/1ns
`default_nettype none
module link_host_model (
   // pins towards the device
   output var flow_trace_pkg::link_pins_t pins,
   input  wire logic                      tdo
);
   localparam int HALF = 80;
   initial pins = '{selN: 1'b1, tck: 1'b0, tdi: 1'b0};
   ////////////////////////////////////////////////////////////////
   // one frame: 8 command bits, then n data bits, lsb first
   task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd,
                       input int n, output logic [31:0] rd);
      int i;
      rd = '0;
      pins.selN = 1'b0;
      #(HALF);
      for (i = 0; i < 8 + n; i++) begin
         pins.tck = 1'b0;
         pins.tdi = (i < 8) ? cmd[i] : wd[i-8];
         #(HALF);
         pins.tck = 1'b1;
         if (i >= 8) rd[i-8] = tdo;
         #(HALF);
      end
      pins.tck = 1'b0;
      #(HALF);
      pins.selN = 1'b1;
      pins.tdi = ~pins.tdi;
      #(HALF);
   endtask
endmodule // link_host_model
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the flow trace ring and its serial port
// assumes link_host_model and the design package are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic                       clk, nrst, cofValid, debugMode;
   logic                       debugAck, linkTdo, linkTdoEn, execAck;
   logic                       tdoEnSeen;
   logic [31:0]                cofAddr, seed, rd;
   logic [2:0]                 tracePtr, ptrExp;
   logic [31:0]                ring [8];
   flow_trace_pkg::link_pins_t pins;
   int                         errorCnt, checksDone, cycles, i;

   debug_flow_trace_fifo uut (.clk(clk), .nrst(nrst), .cofValid(cofValid),
      .cofAddr(cofAddr), .debugMode(debugMode), .debugAck(debugAck),
      .tracePtr(tracePtr), .linkSelN(pins.selN), .linkTck(pins.tck),
      .linkTdi(pins.tdi), .linkTdo(linkTdo), .linkTdoEn(linkTdoEn),
      .execAck(execAck));
   // released tdo has no pull: the host sees the inverse of the last bit
   link_host_model host (.pins(pins), .tdo(linkTdoEn ? linkTdo : ~linkTdo));

   initial clk = 1'b0;
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errorCnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic endOfTest();
      $display("errors=%0d checks=%0d", errorCnt, checksDone);
      if (errorCnt == 0 && checksDone > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // back-to-back capture pulses, ignored while in debug
   task automatic capture(input int n);
      int k;
      for (k = 0; k < n; k++) begin
         @(posedge clk);
         #1;
         seed = nextRand(seed);
         cofValid = 1'b1;
         cofAddr = seed;
         if (!debugMode) begin
            ring[ptrExp] = seed;
            ptrExp = ptrExp + 3'h1;
         end
      end
      @(posedge clk);
      #1;
      cofValid = 1'b0;
      @(posedge clk);
      #1;
      check({29'h0, tracePtr}, {29'h0, ptrExp});
   endtask

   // one complete sequence of eight trace reads
   task automatic readAll();
      int k;
      for (k = 0; k < 8; k++) begin
         tdoEnSeen = 1'b0;
         host.xfer(flow_trace_pkg::CMD_READ_TRACE, 32'h0, 32, rd);
         check(rd, ring[ptrExp]);
         check({31'h0, tdoEnSeen}, 32'h1);
         check({31'h0, linkTdoEn}, 32'h0);
         ptrExp = ptrExp + 3'h1;
         check({29'h0, tracePtr}, {29'h0, ptrExp});
      end
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (linkTdoEn) tdoEnSeen <= 1'b1;
      if (cycles == 40000) begin
         errorCnt++;
         endOfTest();
      end
   end

   initial begin
      nrst = 1'b0;
      cofValid = 1'b0;
      cofAddr = 32'h0;
      debugMode = 1'b0;
      seed = 32'h160E;
      ptrExp = 3'h0;
      errorCnt = 0;
      checksDone = 0;
      cycles = 0;
      tdoEnSeen = 1'b0;
      for (i = 0; i < 8; i++) ring[i] = 32'h0;
      repeat (12) @(posedge clk);
      #1;
      nrst = 1'b1;
      capture(5);
      capture(11);
      debugMode = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, debugAck}, 32'h1);
      capture(6);
      readAll();
      readAll();
      seed = nextRand(seed);
      tdoEnSeen = 1'b0;
      host.xfer(flow_trace_pkg::CMD_WRITE_SCRATCH, seed, 32, rd);
      check({31'h0, execAck}, 32'h1);
      check({31'h0, tdoEnSeen}, 32'h0);
      host.xfer(flow_trace_pkg::CMD_READ_SCRATCH, 32'h0, 32, rd);
      check(rd, seed);
      check({31'h0, execAck}, 32'h0);
      tdoEnSeen = 1'b0;
      host.xfer(flow_trace_pkg::CMD_NOP, 32'h0, 0, rd);
      check({31'h0, execAck}, 32'h1);
      check({31'h0, tdoEnSeen}, 32'h0);
      debugMode = 1'b0;
      capture(3);
      endOfTest();
   end
endmodule // tb_top
`default_nettype wire
